/* core/ecp_pkg.sv */
package ecp_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int POS_W = 32;
  localparam int ANG_W = 10;
  localparam int FRAC_W = 9;
  localparam int ADR_W = 12;
  localparam int IDX_W = 10;
  localparam int MRES_W = 4;
  localparam logic [ANG_W:0] ENC_STEPS = 11'h400;
  localparam logic [POS_W-1:0] PRESC_ONE = 32'h00000200;

  // ****************************************
  // Axis setting indices, byte address is index * 4
  // ****************************************
  localparam logic [IDX_W-1:0] AP_MRES = 10'h08C;
  localparam logic [IDX_W-1:0] AP_INT_POS = 10'h0D1;
  localparam logic [IDX_W-1:0] AP_INT_CFG = 10'h0D2;
  localparam logic [IDX_W-1:0] AP_INT_DEV = 10'h0D4;
  localparam logic [IDX_W-1:0] AP_INT_ABS = 10'h0D7;
  localparam logic [IDX_W-1:0] AP_EXT_POS = 10'h0D8;
  localparam logic [IDX_W-1:0] AP_EXT_CFG = 10'h0D9;
  localparam logic [IDX_W-1:0] AP_EXT_DEV = 10'h0DA;
  localparam logic [IDX_W-1:0] AP_STATUS = 10'h100;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [POS_W-1:0] INT_CFG_RST = 32'h00006400;
  localparam logic [POS_W-1:0] EXT_CFG_RST = 32'h00000200;
  localparam logic [POS_W-1:0] DEV_RST = 32'h00000000;
  localparam logic [MRES_W-1:0] MRES_RST = 4'h8;
  localparam logic [MRES_W-1:0] MRES_MAX = 4'h8;
  localparam logic [MRES_W-1:0] MRES_MIN_AUTO = 4'h1;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int INT_CLR_BIT = 2;
  localparam int EXT_ARM_BIT = 2;
  localparam int EXT_EVERY_BIT = 3;
  localparam int EXT_POL_BIT = 4;
  localparam int ST_INT_DEV_BIT = 0;
  localparam int ST_EXT_DEV_BIT = 1;
  localparam int ST_EXT_ARM_BIT = 2;
endpackage

/* core/ecp_scaler.sv */
`timescale 1ns/1ps
module ecp_scaler
  import ecp_pkg::*;
#(
  parameter int DW = ANG_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic signed [DW-1:0] delta_i,
  input wire logic [POS_W-1:0] presc_i,
  input wire logic load_i,
  input wire logic [POS_W-1:0] load_val_i,
  input wire logic clear_i,
  output logic [POS_W-1:0] pos_o
);
  localparam int ACC_W = POS_W + FRAC_W;
  localparam int PW = POS_W + 1 + DW;

  logic signed [ACC_W-1:0] acc;
  logic signed [PW-1:0] prod;
  logic signed [ACC_W-1:0] inc;
  logic signed [ACC_W-1:0] next_acc;

  // Prescaler p scales by p/512: fraction bits carry the remainder
  assign prod = $signed({1'b0, presc_i}) * delta_i;
  assign inc = ACC_W'(prod);
  assign next_acc = acc + inc;
  assign pos_o = acc[ACC_W-1:FRAC_W];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= '0;
    end else if (load_i) begin
      acc <= {load_val_i, {FRAC_W{1'b0}}};
    end else if (clear_i) begin
      acc <= '0;
    end else if (step_i) begin
      acc <= next_acc;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_load_takes;
    @(posedge clk_i) disable iff (rst_i) load_i |=> pos_o == $past(load_val_i);
  endproperty
  a_load_takes: assert property (p_load_takes) else $error("position load lost");

  property p_step_adds;
    @(posedge clk_i) disable iff (rst_i) (step_i && !load_i && !clear_i) |=> acc == $past(next_acc);
  endproperty
  a_step_adds: assert property (p_step_adds) else $error("scaled step not accumulated");
endmodule

/* core/ecp_top.sv */
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module ecp_top
  import ecp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [POS_W-1:0] wb_dat_i,
  output logic [POS_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [ANG_W-1:0] angle_i,
  input wire logic angle_vld_i,
  input wire logic [POS_W-1:0] motor_pos_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic enc_n_i,
  output logic [MRES_W-1:0] mres_o,
  output logic stop_o
);
  // ****************************************
  // Bus decode
  // ****************************************
  logic [POS_W-1:0] int_cfg;
  logic [POS_W-1:0] ext_cfg;
  logic [POS_W-1:0] int_dev;
  logic [POS_W-1:0] ext_dev;
  logic [MRES_W-1:0] mres;
  logic [ANG_W-1:0] angle;
  logic [1:0] dev_err;
  logic [POS_W-1:0] int_pos;
  logic [POS_W-1:0] ext_pos;

  function automatic logic [POS_W-1:0] merge(input logic [POS_W-1:0] old_v, input logic [POS_W-1:0] new_v,
                                             input logic [3:0] sel);
    logic [POS_W-1:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i;
  wire [IDX_W-1:0] idx = wb_adr_i[ADR_W-1:2];
  wire wr_mres = wr && idx == AP_MRES;
  wire wr_int_pos = wr && idx == AP_INT_POS;
  wire wr_int_cfg = wr && idx == AP_INT_CFG;
  wire wr_int_dev = wr && idx == AP_INT_DEV;
  wire wr_ext_pos = wr && idx == AP_EXT_POS;
  wire wr_ext_cfg = wr && idx == AP_EXT_CFG;
  wire wr_ext_dev = wr && idx == AP_EXT_DEV;
  wire wr_status = wr && idx == AP_STATUS;
  wire [POS_W-1:0] wdat_int_cfg = merge(int_cfg, wb_dat_i, wb_sel_i);
  wire [POS_W-1:0] wdat_ext_cfg = merge(ext_cfg, wb_dat_i, wb_sel_i);
  wire [POS_W-1:0] wdat_int_pos = merge(int_pos, wb_dat_i, wb_sel_i);
  wire [POS_W-1:0] wdat_ext_pos = merge(ext_pos, wb_dat_i, wb_sel_i);
  wire [POS_W-1:0] wdat_mres = merge({{(POS_W-MRES_W){1'b0}}, mres}, wb_dat_i, wb_sel_i);
  wire [POS_W-1:0] wdat_status = merge('0, wb_dat_i, wb_sel_i);

  // Read mux, unmapped indices read zero
  wire [POS_W-1:0] status_word = {{(POS_W-3){1'b0}}, ext_cfg[EXT_ARM_BIT], dev_err};
  wire [POS_W-1:0] rd_data =
    (idx == AP_MRES) ? {{(POS_W-MRES_W){1'b0}}, mres} :
    (idx == AP_INT_POS) ? int_pos :
    (idx == AP_INT_CFG) ? int_cfg :
    (idx == AP_INT_DEV) ? int_dev :
    (idx == AP_INT_ABS) ? {{(POS_W-ANG_W){1'b0}}, angle} :
    (idx == AP_EXT_POS) ? ext_pos :
    (idx == AP_EXT_CFG) ? ext_cfg :
    (idx == AP_EXT_DEV) ? ext_dev :
    (idx == AP_STATUS) ? status_word : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // ****************************************
  // Microstep resolution and configuration
  // ****************************************
  // Writes above 8 are ignored
  wire mres_ok = wdat_mres <= {{(POS_W-MRES_W){1'b0}}, MRES_MAX};
  wire [MRES_W-1:0] mres_eff = (wdat_mres[MRES_W-1:0] < MRES_MIN_AUTO) ? MRES_MIN_AUTO : wdat_mres[MRES_W-1:0];
  // Resolution change rescales the internal prescaler, function bits kept
  wire [POS_W-1:0] auto_presc = INT_CFG_RST >> (MRES_MAX - mres_eff);
  wire [POS_W-1:0] auto_int_cfg = {auto_presc[POS_W-1:4], int_cfg[3:0]};

  logic ext_null_ev;
  wire ext_arm_done = ext_null_ev && ext_cfg[EXT_ARM_BIT] && !ext_cfg[EXT_EVERY_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mres <= MRES_RST;
      int_cfg <= INT_CFG_RST;
      ext_cfg <= EXT_CFG_RST;
      int_dev <= DEV_RST;
      ext_dev <= DEV_RST;
    end else begin
      if (wr_mres && mres_ok) begin
        mres <= wdat_mres[MRES_W-1:0];
      end
      if (wr_int_cfg) begin
        int_cfg <= wdat_int_cfg;
      end else if (wr_mres && mres_ok) begin
        int_cfg <= auto_int_cfg;
      end
      if (wr_ext_cfg) begin
        ext_cfg <= wdat_ext_cfg;
      end else if (ext_arm_done) begin
        ext_cfg[EXT_ARM_BIT] <= 1'b0;
      end
      if (wr_int_dev) begin
        int_dev <= merge(int_dev, wb_dat_i, wb_sel_i);
      end
      if (wr_ext_dev) begin
        ext_dev <= merge(ext_dev, wb_dat_i, wb_sel_i);
      end
    end
  end
  assign mres_o = mres;

  // ****************************************
  // Internal magnetic encoder
  // ****************************************
  logic ang_seen;
  // Ring of 1024 steps: modular difference is the signed move
  wire signed [ANG_W-1:0] ang_delta = $signed(angle_i - angle);
  wire ang_move = angle_vld_i && ang_seen && ang_delta != '0;
  wire ang_wrap = ang_move && ((ang_delta > 0 && angle_i < angle) || (ang_delta < 0 && angle_i > angle)
                  || angle_i == '0);
  wire int_clr = ang_wrap && int_cfg[INT_CLR_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      angle <= '0;
      ang_seen <= 1'b0;
    end else if (angle_vld_i) begin
      angle <= angle_i;
      ang_seen <= 1'b1;
    end
  end

  // Full config word is the prescaler, clear bit 2 included
  ecp_scaler #(.DW(ANG_W)) u_int_scaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(ang_move),
    .delta_i(ang_delta),
    .presc_i(int_cfg),
    .load_i(wr_int_pos),
    .load_val_i(wdat_int_pos),
    .clear_i(int_clr),
    .pos_o(int_pos)
  );

  // ****************************************
  // External ABN encoder
  // ****************************************
  logic [2:0] a_sync;
  logic [2:0] b_sync;
  logic [2:0] n_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_sync <= '0;
      b_sync <= '0;
      n_sync <= '0;
    end else begin
      a_sync <= {a_sync[1:0], enc_a_i};
      b_sync <= {b_sync[1:0], enc_b_i};
      n_sync <= {n_sync[1:0], enc_n_i};
    end
  end

  // An edge of A or of B alone is one count (edges of both in one cycle give none), direction from phase order
  wire quad_step = (a_sync[2] ^ a_sync[1]) ^ (b_sync[2] ^ b_sync[1]);
  wire quad_up = a_sync[2] ^ b_sync[1];
  wire signed [ANG_W-1:0] quad_delta = quad_up ? ANG_W'(1) : -ANG_W'(1);
  // Null event: entering the selected level
  wire n_level = n_sync[1] == ext_cfg[EXT_POL_BIT];
  wire n_prev = n_sync[2] == ext_cfg[EXT_POL_BIT];
  assign ext_null_ev = n_level && !n_prev;
  wire ext_clr = ext_null_ev && ext_cfg[EXT_ARM_BIT];

  // Full config word is the prescaler, bits 2..4 included
  ecp_scaler #(.DW(ANG_W)) u_ext_scaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(quad_step),
    .delta_i(quad_delta),
    .presc_i(ext_cfg),
    .load_i(wr_ext_pos),
    .load_val_i(wdat_ext_pos),
    .clear_i(ext_clr),
    .pos_o(ext_pos)
  );

  // ****************************************
  // Deviation supervision
  // ****************************************
  wire signed [POS_W:0] int_diff = $signed({motor_pos_i[POS_W-1], motor_pos_i}) - $signed({int_pos[POS_W-1], int_pos});
  wire signed [POS_W:0] ext_diff = $signed({motor_pos_i[POS_W-1], motor_pos_i}) - $signed({ext_pos[POS_W-1], ext_pos});
  wire [POS_W:0] int_abs = int_diff[POS_W] ? POS_W'(0) - int_diff : int_diff;
  wire [POS_W:0] ext_abs = ext_diff[POS_W] ? POS_W'(0) - ext_diff : ext_diff;
  wire int_exceed = int_dev != '0 && int_abs > {1'b0, int_dev};
  wire ext_exceed = ext_dev != '0 && ext_abs > {1'b0, ext_dev};
  wire [1:0] dev_hit = {ext_exceed, int_exceed};
  wire [1:0] dev_w1c = wr_status ? wdat_status[ST_EXT_DEV_BIT:ST_INT_DEV_BIT] : 2'h0;

  // Sticky, write one clears, a new hit wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dev_err <= 2'h0;
    end else begin
      dev_err <= (dev_err & ~dev_w1c) | dev_hit;
    end
  end
  assign stop_o = |dev_err;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i) s_req |=> s_ack_pulse;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack not a single cycle after request");

  property p_mres_range;
    @(posedge clk_i) disable iff (rst_i) mres_o <= MRES_MAX;
  endproperty
  a_mres_range: assert property (p_mres_range) else $error("microstep resolution out of range");

  property p_abs_read;
    @(posedge clk_i) disable iff (rst_i) (s_req and (!wb_we_i && idx == AP_INT_ABS)) |=>
      wb_dat_o == {{(POS_W-ANG_W){1'b0}}, $past(angle)};
  endproperty
  a_abs_read: assert property (p_abs_read) else $error("absolute angle read wrong");

  property p_int_stop;
    @(posedge clk_i) disable iff (rst_i) int_exceed |=> stop_o && dev_err[ST_INT_DEV_BIT];
  endproperty
  a_int_stop: assert property (p_int_stop) else $error("internal deviation did not stop");

  property p_ext_stop;
    @(posedge clk_i) disable iff (rst_i) ext_exceed |=> stop_o && dev_err[ST_EXT_DEV_BIT];
  endproperty
  a_ext_stop: assert property (p_ext_stop) else $error("external deviation did not stop");

  property p_dev_off;
    @(posedge clk_i) disable iff (rst_i) (int_dev == '0) |-> !int_exceed;
  endproperty
  a_dev_off: assert property (p_dev_off) else $error("zero maximum deviation still supervises");

  property p_int_zero;
    @(posedge clk_i) disable iff (rst_i) (int_clr && !wr_int_pos) |=> int_pos == '0;
  endproperty
  a_int_zero: assert property (p_int_zero) else $error("zero crossing did not clear");

  property p_ext_zero;
    @(posedge clk_i) disable iff (rst_i) (ext_clr && !wr_ext_pos) |=> ext_pos == '0;
  endproperty
  a_ext_zero: assert property (p_ext_zero) else $error("null event did not clear");

  property p_arm_once;
    @(posedge clk_i) disable iff (rst_i) (ext_arm_done && !wr_ext_cfg) |=> !ext_cfg[EXT_ARM_BIT];
  endproperty
  a_arm_once: assert property (p_arm_once) else $error("one-shot null clear stayed armed");

  property p_arm_every;
    @(posedge clk_i) disable iff (rst_i) (ext_cfg[EXT_ARM_BIT] && ext_cfg[EXT_EVERY_BIT] && !wr_ext_cfg) |=>
      ext_cfg[EXT_ARM_BIT];
  endproperty
  a_arm_every: assert property (p_arm_every) else $error("repeating null clear disarmed");

  property p_quad_edge;
    @(posedge clk_i) disable iff (rst_i) ($changed(a_sync[1]) && $stable(b_sync[1])) |-> quad_step;
  endproperty
  a_quad_edge: assert property (p_quad_edge) else $error("phase edge not counted");
endmodule

/* dv/ecp_enc_model.sv */
`timescale 1ns/1ps
// ****************************************
// Far-side encoder model
// ****************************************
module ecp_enc_model (
  input wire logic clk_i,
  output logic [9:0] angle_o,
  output logic angle_vld_o,
  output logic a_o,
  output logic b_o,
  output logic n_o
);
  logic [1:0] q = 2'h0;
  initial begin
    angle_o = 10'h000;
    angle_vld_o = 1'b0;
    a_o = 1'b0;
    b_o = 1'b0;
    n_o = 1'b0;
  end
  // Angle wraps every 1024 counts, scrambled outside its strobe
  task turn(input logic [9:0] a);
    @(posedge clk_i);
    angle_o <= a;
    angle_vld_o <= 1'b1;
    @(posedge clk_i);
    angle_o <= ~a;
    angle_vld_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // Gray sequence, one phase edge per step
  task quad(input int dir);
    q = q + dir[1:0];
    @(posedge clk_i);
    a_o <= q[1];
    b_o <= q[1] ^ q[0];
    repeat (4) @(posedge clk_i);
  endtask
  task null_pulse(input logic lvl);
    @(posedge clk_i);
    n_o <= lvl;
    repeat (4) @(posedge clk_i);
    n_o <= ~lvl;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

/* dv/ecp_top_tb.sv */
`timescale 1ns/1ps
module ecp_top_tb;
  import ecp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [POS_W-1:0] wb_dat_i = 32'h0;
  logic [POS_W-1:0] motor_pos_i = 32'h0;
  logic [POS_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic [ANG_W-1:0] angle_i;
  logic angle_vld_i, enc_a_i, enc_b_i, enc_n_i, stop_o;
  logic [MRES_W-1:0] mres_o;
  logic [9:0] prev = 10'h000;
  logic [31:0] v, e, base;
  logic [3:0] sl;
  int bad_count = 0;
  int n_compared = 0;
  int p_i, p_e;
  longint acc_i, acc_e;

  always #4 clk_i = ~clk_i;

  ecp_top i_ecp_top (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .angle_i, .angle_vld_i, .motor_pos_i, .enc_a_i, .enc_b_i, .enc_n_i, .mres_o, .stop_o);
  ecp_enc_model i_ecp_enc_model (.clk_i(clk_i), .angle_o(angle_i), .angle_vld_o(angle_vld_i),
    .a_o(enc_a_i), .b_o(enc_b_i), .n_o(enc_n_i));

  // ****************************************
  // Report and compare
  // ****************************************
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_pin(input string nm, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // ****************************************
  // Bus and stimulus
  // ****************************************
  task wb(input logic [IDX_W-1:0] idx, input logic we, input logic [31:0] d, input logic [3:0] sel,
          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= d;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (n >= 40) bad_count++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    logic [31:0] x;
    wb(idx, 1'b1, d, 4'hF, x);
  endtask
  task rchk(input string nm, input logic [IDX_W-1:0] idx, input logic [31:0] e);
    logic [31:0] x;
    wb(idx, 1'b0, 32'h0, 4'hF, x);
    chk_reg(nm, e, x);
  endtask
  task ang(input logic [9:0] a);
    logic signed [9:0] d;
    d = a - prev;
    acc_i += longint'(p_i) * d;
    prev = a;
    i_ecp_enc_model.turn(a);
  endtask
  task qd(input int dir, input int n);
    repeat (n) begin
      i_ecp_enc_model.quad(dir);
      acc_e += longint'(p_e) * dir;
    end
  endtask
  task setm(input logic [31:0] m);
    @(posedge clk_i);
    motor_pos_i <= m;
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    void'($urandom(69044));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("mres", AP_MRES, 32'h8);
    rchk("icfg", AP_INT_CFG, 32'h00006400);
    rchk("ecfg", AP_EXT_CFG, 32'h00000200);
    rchk("idev", AP_INT_DEV, 32'h0);
    rchk("edev", AP_EXT_DEV, 32'h0);
    wr(10'h3FF, 32'hA5A5A5A5);
    rchk("unmapped", 10'h3FF, 32'h0);
    // Byte enables: only selected bytes land
    v = $urandom;
    sl = 4'($urandom);
    wb(AP_EXT_DEV, 1'b1, v, sl, e);
    e = 32'h0;
    for (int j = 0; j < 4; j++) begin
      if (sl[j]) begin
        e[j*8 +: 8] = v[j*8 +: 8];
      end
    end
    rchk("edev_sel", AP_EXT_DEV, e);
    wr(AP_EXT_DEV, 32'h0);
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 32'h80000000 : (k == 1) ? 32'h7FFFFFFF : $urandom;
      wr(AP_INT_POS, v);
      rchk("ipos", AP_INT_POS, v);
      wr(AP_EXT_POS, ~v);
      rchk("epos", AP_EXT_POS, ~v);
    end
    // Seed angle, then scale 1 and 50 with random moves and one full turn
    i_ecp_enc_model.turn(10'h000);
    for (int s = 0; s < 2; s++) begin
      p_i = s ? 25600 : 512;
      wr(AP_INT_CFG, 32'(p_i));
      rchk("icfg", AP_INT_CFG, 32'(p_i));
      wr(AP_INT_POS, 32'h0);
      acc_i = 0;
      repeat (6) ang(prev + 10'($urandom_range(400)) - 10'd200);
      repeat (8) ang(prev + 10'd128);
      rchk("ipos", AP_INT_POS, 32'(acc_i >>> 9));
      rchk("abs", AP_INT_ABS, {22'h0, prev});
    end
    for (int r = 1; r <= 8; r++) begin
      wr(AP_MRES, 32'(r));
      chk_pin("mres_o", 4'(r), mres_o);
      rchk("icfg", AP_INT_CFG, (32'd25600 >> (8 - r)) & 32'hFFFFFFF0);
    end
    wr(AP_MRES, 32'h9);
    chk_pin("mres_o", 4'h8, mres_o);
    wr(AP_MRES, 32'h6);
    p_i = 6400;
    wr(AP_INT_POS, 32'h0);
    acc_i = 0;
    repeat (5) ang(prev + 10'd1);
    rchk("ipos", AP_INT_POS, 32'(acc_i >>> 9));
    p_i = 516;
    wr(AP_INT_CFG, 32'(p_i));
    ang(10'd5);
    ang(10'd0);
    acc_i = 0;
    rchk("ipos", AP_INT_POS, 32'h0);
    ang(10'd3);
    rchk("ipos", AP_INT_POS, 32'(acc_i >>> 9));
    // External quadrature at scale 2 and 0.5
    for (int s = 0; s < 2; s++) begin
      p_e = s ? 256 : 1024;
      wr(AP_EXT_CFG, 32'(p_e));
      rchk("ecfg", AP_EXT_CFG, 32'(p_e));
      wr(AP_EXT_POS, 32'h0);
      acc_e = 0;
      qd(1, 6);
      qd(-s, 2);
      rchk("epos", AP_EXT_POS, 32'(acc_e >>> 9));
    end
    // Null clearing: once, every, both levels
    wr(AP_EXT_CFG, 32'd532);
    rchk("status", AP_STATUS, 32'h4);
    wr(AP_EXT_POS, 32'd100);
    i_ecp_enc_model.null_pulse(1'b1);
    rchk("epos", AP_EXT_POS, 32'h0);
    rchk("status", AP_STATUS, 32'h0);
    wr(AP_EXT_POS, 32'd50);
    i_ecp_enc_model.null_pulse(1'b1);
    rchk("epos", AP_EXT_POS, 32'd50);
    wr(AP_EXT_CFG, 32'd540);
    repeat (2) begin
      wr(AP_EXT_POS, 32'd30);
      i_ecp_enc_model.null_pulse(1'b1);
      rchk("epos", AP_EXT_POS, 32'h0);
    end
    wr(AP_EXT_CFG, 32'd528);
    wr(AP_EXT_POS, 32'd40);
    i_ecp_enc_model.null_pulse(1'b0);
    rchk("epos", AP_EXT_POS, 32'd40);
    wr(AP_EXT_CFG, 32'd516);
    wr(AP_EXT_POS, 32'd77);
    i_ecp_enc_model.null_pulse(1'b0);
    rchk("epos", AP_EXT_POS, 32'h0);
    // Deviation supervision
    // Motor brought to the encoder position before the limit is armed
    base = $urandom & 32'h3FFFFFFF;
    wr(AP_INT_POS, base);
    setm(base);
    wr(AP_INT_DEV, 32'd10);
    setm(base + 32'd10);
    chk_pin("stop_o", 4'h0, {3'h0, stop_o});
    setm(base + 32'd11);
    chk_pin("stop_o", 4'h1, {3'h0, stop_o});
    rchk("status", AP_STATUS, 32'h1);
    setm(base);
    wr(AP_STATUS, 32'h1);
    chk_pin("stop_o", 4'h0, {3'h0, stop_o});
    wr(AP_EXT_POS, base - 32'd10);
    wr(AP_EXT_DEV, 32'd5);
    setm(base);
    chk_pin("stop_o", 4'h1, {3'h0, stop_o});
    rchk("status", AP_STATUS, 32'h2);
    wr(AP_EXT_DEV, 32'h0);
    wr(AP_STATUS, 32'h2);
    setm(base);
    chk_pin("stop_o", 4'h0, {3'h0, stop_o});
    final_report;
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    final_report;
  end
endmodule
